// ---- common/rcs_pkg.sv ----
// Constants and types shared by the reset and configuration sequencer.
package rcs_pkg;

   // ==========================================================
   // Widths and timing
   // ==========================================================
   localparam int unsigned CFG_W         = 16;
   localparam int unsigned CNT_W         = 32;
   localparam int unsigned WAIT_W        = 24;
   localparam int unsigned CLK_MHZ       = 100;
   localparam int unsigned PLL_LOCK_US   = 100;
   localparam int unsigned PLL_WAIT_CYC  = PLL_LOCK_US * CLK_MHZ;
   localparam int unsigned HRST_IN_MIN   = 32;
   localparam int unsigned HRST_OUT_CYC  = 32;
   localparam int unsigned CFG_SETUP_CYC = 4;
   localparam int unsigned CFG_HOLD_CYC  = 2;
   localparam int unsigned CFG_FLOAT_CYC = 5;
   localparam int unsigned POR_MIN_MS    = 1;
   localparam int unsigned TREF_MIN_PER  = 16;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [CFG_W-1:0] CFG_RST = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;

   // ==========================================================
   // Sequencer states
   // ==========================================================
   typedef enum logic [4:0] {
      RCS_POR   = 5'b0_0001,
      RCS_PLL   = 5'b0_0010,
      RCS_HOLD  = 5'b0_0100,
      RCS_RUN   = 5'b0_1000,
      RCS_EXTHR = 5'b1_0000
   } rcs_state_t;

   typedef struct packed {
      logic             valid;
      logic [CFG_W-1:0] value;
   } rcs_cfg_t;

   typedef struct packed {
      logic             tick;
      logic [CNT_W-1:0] intrCtrlCount;
      logic [CNT_W-1:0] timeBase;
   } rcs_tref_t;

endpackage : rcs_pkg

// ---- design/rcs_sync.sv ----
// Two-flop level synchroniser, parameterised in width.
`timescale 1ns/100ps
module rcs_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   input  wire logic         clkEn,
   input  wire logic [W-1:0] asyncIn,
   output logic      [W-1:0] syncOut
);
   // The first stage is read only by the second stage.
   logic [W-1:0] stage1;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stage1  <= '0;
         syncOut <= '0;
      end else if (clkEn) begin
         stage1  <= asyncIn;
         syncOut <= stage1;
      end
   end
endmodule : rcs_sync

// ---- design/reset_config_sequencer.sv ----
// Power-on and hard reset sequencer with time-reference counters.
`timescale 1ns/100ps
module reset_config_sequencer #(
   parameter int unsigned PLL_WAIT = rcs_pkg::PLL_WAIT_CYC
) (
   input  wire logic                      clk_sys,
   input  wire logic                      rst_n,
   input  wire logic                      clkEn,
   input  wire logic                      power_on_reset_n,
   input  wire logic                      hardResetIn,
   output logic                           hardResetOut,
   output logic                           hardResetOe,
   input  wire logic [rcs_pkg::CFG_W-1:0] porConfigIn,
   output rcs_pkg::rcs_cfg_t              porConfig,
   input  wire logic                      pllLock,
   output logic                           pllStart,
   output logic                           pllResetN,
   output logic                           pllTimeout,
   input  wire logic                      timeRefIn,
   output rcs_pkg::rcs_tref_t             timeRef
);
   // ==========================================================
   // Input capture
   // ==========================================================
   // Reset pins are synchronous inputs; the time reference and the
   // lock indication come from other domains and are synchronised.
   logic                        porN;
   logic                        porNPrev;
   logic                        hrIn;
   logic [rcs_pkg::CFG_W-1:0]   cfgPrev;
   logic [1:0]                  syncd;
   logic                        trefPrev;
   logic                        trefSync;
   logic                        lockSync;

   rcs_sync #(.W(2)) uSync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .clkEn   (clkEn),
      .asyncIn ({timeRefIn, pllLock}),
      .syncOut (syncd)
   );

   assign trefSync = syncd[1];
   assign lockSync = syncd[0];

   // Power-on reset reads as asserted out of reset, matching a board
   // that holds it low while supplies ramp.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         porN     <= 1'b0;
         porNPrev <= 1'b0;
         hrIn     <= 1'b1;
         cfgPrev  <= rcs_pkg::CFG_RST;
      end else if (clkEn) begin
         porN     <= power_on_reset_n;
         porNPrev <= porN;
         hrIn     <= hardResetIn;
         cfgPrev  <= porConfigIn;
      end
   end

   // ==========================================================
   // Sequencer
   // ==========================================================
   rcs_pkg::rcs_state_t         state;
   rcs_pkg::rcs_state_t         next_state;
   logic [rcs_pkg::WAIT_W-1:0]  waitCnt;
   logic [5:0]                  lowCnt;
   logic                        porRise;
   logic                        waitDone;
   logic                        holdDone;
   logic                        extLong;

   localparam logic [rcs_pkg::WAIT_W-1:0] PLL_LAST =
      rcs_pkg::WAIT_W'(PLL_WAIT - 1);
   localparam logic [rcs_pkg::WAIT_W-1:0] HOLD_LAST =
      rcs_pkg::WAIT_W'(rcs_pkg::HRST_OUT_CYC - 1);
   localparam logic [5:0] EXT_LAST = 6'(rcs_pkg::HRST_IN_MIN - 1);

   assign porRise  = porN && !porNPrev;
   assign waitDone = (waitCnt == PLL_LAST);
   assign holdDone = (waitCnt == HOLD_LAST);
   assign extLong  = (lowCnt == EXT_LAST);

   always_comb begin
      next_state = state;
      unique case (state)
         rcs_pkg::RCS_POR: begin
            if (porRise) begin
               next_state = rcs_pkg::RCS_PLL;
            end
         end
         rcs_pkg::RCS_PLL: begin
            if (lockSync || waitDone) begin
               next_state = rcs_pkg::RCS_HOLD;
            end
         end
         rcs_pkg::RCS_HOLD: begin
            if (holdDone) begin
               next_state = rcs_pkg::RCS_RUN;
            end
         end
         rcs_pkg::RCS_RUN: begin
            if (!hrIn && extLong) begin
               next_state = rcs_pkg::RCS_EXTHR;
            end
         end
         rcs_pkg::RCS_EXTHR: begin
            if (hrIn) begin
               next_state = rcs_pkg::RCS_HOLD;
            end
         end
         default: begin
            next_state = rcs_pkg::RCS_POR;
         end
      endcase
      // Power-on reset overrides every other state.
      if (!porN) begin
         next_state = rcs_pkg::RCS_POR;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state <= rcs_pkg::RCS_POR;
      end else if (clkEn) begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         waitCnt <= '0;
      end else if (clkEn) begin
         // Saturating at all ones rather than at the PLL limit lets the
         // hold count reach its end even when the PLL wait is shorter.
         if (next_state != state) begin
            waitCnt <= '0;
         end else if (waitCnt != '1) begin
            waitCnt <= waitCnt + 1'b1;
         end
      end
   end

   // Counts how long an outside agent keeps hard reset low; shorter
   // pulses are treated as glitches and ignored.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lowCnt <= '0;
      end else if (clkEn) begin
         if (hrIn || state != rcs_pkg::RCS_RUN) begin
            lowCnt <= '0;
         end else if (!extLong) begin
            lowCnt <= lowCnt + 1'b1;
         end
      end
   end

   // ==========================================================
   // Pin and PLL control
   // ==========================================================
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hardResetOut <= 1'b0;
         hardResetOe  <= 1'b1;
         pllStart     <= 1'b0;
         pllResetN    <= 1'b0;
         pllTimeout   <= 1'b0;
      end else if (clkEn) begin
         hardResetOut <= 1'b0;
         hardResetOe  <= (next_state != rcs_pkg::RCS_RUN) &&
                         (next_state != rcs_pkg::RCS_EXTHR);
         pllStart     <= (next_state != rcs_pkg::RCS_POR);
         pllResetN    <= (next_state == rcs_pkg::RCS_HOLD) ||
                         (next_state == rcs_pkg::RCS_RUN) ||
                         (next_state == rcs_pkg::RCS_EXTHR);
         if (state == rcs_pkg::RCS_POR) begin
            pllTimeout <= 1'b0;
         end else if (state == rcs_pkg::RCS_PLL && waitDone && !lockSync) begin
            pllTimeout <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Configuration capture
   // ==========================================================
   // Straps are sampled on the same clock that registers the rising edge: inside
   // the hold window and before drivers may float.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         porConfig <= '{valid: 1'b0, value: rcs_pkg::CFG_RST};
      end else if (clkEn) begin
         if (!porN) begin
            porConfig.valid <= 1'b0;
         end else if (porRise) begin
            porConfig.value <= cfgPrev;
            porConfig.valid <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Time reference
   // ==========================================================
   // A grounded input never rises, so both counters stay put.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         trefPrev <= 1'b0;
         timeRef  <= '{tick: 1'b0, intrCtrlCount: rcs_pkg::CNT_RST,
                       timeBase: rcs_pkg::CNT_RST};
      end else if (clkEn) begin
         trefPrev     <= trefSync;
         timeRef.tick <= trefSync && !trefPrev;
         if (state != rcs_pkg::RCS_RUN) begin
            timeRef.intrCtrlCount <= rcs_pkg::CNT_RST;
            timeRef.timeBase      <= rcs_pkg::CNT_RST;
         end else if (trefSync && !trefPrev) begin
            timeRef.intrCtrlCount <= timeRef.intrCtrlCount + 1'b1;
            timeRef.timeBase      <= timeRef.timeBase + 1'b1;
         end
      end
   end

endmodule : reset_config_sequencer

// ---- verif/rcs_board_model.sv ----
// Board supervisor, strap drivers, lock source and time reference.
`timescale 1ns/100ps
module rcs_board_model #(
   parameter int POR_CYC = 64
) (
   input wire logic   clk_sys,
   input wire logic   hardResetOut,
   input wire logic   hardResetOe,
   output logic       power_on_reset_n,
   output logic       hardResetIn,
   output logic [15:0] porConfigIn,
   output logic       pllLock,
   output logic       timeRefIn
);
   // ==========================================================
   // Wire and tasks
   // ==========================================================
   logic extLow = 1'b0;
   // The hard reset wire has a pull-up; either party pulls it low.
   assign hardResetIn = (hardResetOe ? hardResetOut : 1'b1) & !extLow;
   initial begin
      power_on_reset_n = 1'b0;
      porConfigIn = 16'h0000;
      pllLock = 1'b0;
      timeRefIn = 1'b0;
   end
   // POR_CYC is far shorter than the real minimum to keep runs short.
   task por_assert();
      @(negedge clk_sys);
      power_on_reset_n = 1'b0;
      pllLock = 1'b0;
      repeat (POR_CYC) @(negedge clk_sys);
   endtask : por_assert
   task por_release(input logic [15:0] strap, input int lockDly);
      porConfigIn = strap;
      repeat (rcs_pkg::CFG_SETUP_CYC) @(negedge clk_sys);
      power_on_reset_n = 1'b1;
      repeat (rcs_pkg::CFG_HOLD_CYC) @(negedge clk_sys);
      porConfigIn = ~strap;
      if (lockDly != 0) begin
         fork
            begin
               repeat (lockDly) @(negedge clk_sys);
               pllLock = 1'b1;
            end
         join_none
      end
   endtask : por_release
   task ext_hr(input int n);
      extLow = 1'b1;
      repeat (n) @(negedge clk_sys);
      extLow = 1'b0;
   endtask : ext_hr
   task tref(input int n, input int half);
      repeat (n) begin
         timeRefIn = 1'b1;
         repeat (half) @(negedge clk_sys);
         timeRefIn = 1'b0;
         repeat (half) @(negedge clk_sys);
      end
   endtask : tref
endmodule : rcs_board_model

// ---- verif/rcs_checker_assertions.sv ----
// Concurrent checks on the reset and configuration sequencer ports.
`timescale 1ns/100ps
module rcs_checker #(
   parameter int unsigned PLL_WAIT = 20
) (
   input wire logic               clk_sys,
   input wire logic               rst_n,
   input wire logic               power_on_reset_n,
   input wire logic               hardResetOut,
   input wire logic               hardResetOe,
   input wire rcs_pkg::rcs_cfg_t  porConfig,
   input wire logic               pllStart,
   input wire logic               pllResetN,
   input wire rcs_pkg::rcs_tref_t timeRef
);
   // ==========================================================
   // Helper logic
   // ==========================================================
   // Counts the PLL wait so a wait more than four cycles beyond the limit is caught.
   int waitCnt;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         waitCnt <= 0;
      end else if (pllStart && !pllResetN) begin
         waitCnt <= waitCnt + 1;
      end else begin
         waitCnt <= 0;
      end
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   // ==========================================================
   // Assertions
   // ==========================================================
   chk_por_drives_line: assert property (
      !power_on_reset_n [*3] |-> hardResetOe && !hardResetOut)
      else $error("hard reset not driven during power-on reset");
   chk_cfg_cleared: assert property (
      !power_on_reset_n [*3] |-> !porConfig.valid && !pllStart)
      else $error("config or PLL active during power-on reset");
   chk_cfg_held: assert property (
      porConfig.valid && $past(porConfig.valid)
      |-> $stable(porConfig.value))
      else $error("captured config changed");
   chk_pll_wait: assert property (
      waitCnt <= PLL_WAIT + 4)
      else $error("PLL wait too long");
   chk_pll_held: assert property (
      $rose(pllResetN) |-> $past(pllStart))
      else $error("PLL logic released before start");
   chk_hold_after_lock: assert property (
      $rose(pllResetN) |-> hardResetOe [*8])
      else $error("hard reset dropped right after lock");
   chk_tick_single: assert property (
      timeRef.tick |=> !timeRef.tick)
      else $error("tick longer than one cycle");
   chk_tick_count: assert property (
      timeRef.tick && timeRef.intrCtrlCount != 0
      |-> timeRef.intrCtrlCount == $past(timeRef.intrCtrlCount) + 1)
      else $error("tick did not add one");
   chk_count_idle: assert property (
      !timeRef.tick |-> $stable(timeRef.intrCtrlCount)
      || timeRef.intrCtrlCount == 0)
      else $error("counter moved without tick");
   chk_bases_agree: assert property (
      timeRef.intrCtrlCount == timeRef.timeBase)
      else $error("time base and interrupt count differ");
endmodule : rcs_checker

bind reset_config_sequencer rcs_checker #(.PLL_WAIT(PLL_WAIT)) u_chk (
   .clk_sys(clk_sys), .rst_n(rst_n), .power_on_reset_n(power_on_reset_n),
   .hardResetOut(hardResetOut), .hardResetOe(hardResetOe),
   .porConfig(porConfig), .pllStart(pllStart), .pllResetN(pllResetN),
   .timeRef(timeRef));

// ---- verif/tb_reset_config_sequencer.sv ----
// Self-checking bench for the reset and configuration sequencer.
`timescale 1ns/100ps
module tb_reset_config_sequencer;
   localparam int unsigned PW = 20;
   logic               clk_sys = 1'b0;
   logic               rst_n = 1'b0;
   logic               clkEn = 1'b1;
   logic               power_on_reset_n, hardResetIn, pllLock, timeRefIn;
   logic               hardResetOut, hardResetOe;
   logic               pllStart, pllResetN, pllTimeout;
   logic [15:0]        porConfigIn;
   rcs_pkg::rcs_cfg_t  porConfig;
   rcs_pkg::rcs_tref_t timeRef;
   int                 fail_count = 0;
   int                 n_compared = 0;

   always #5 clk_sys = ~clk_sys;

   reset_config_sequencer #(.PLL_WAIT(PW)) dut (.clk_sys(clk_sys),
      .rst_n(rst_n), .clkEn(clkEn), .power_on_reset_n(power_on_reset_n),
      .hardResetIn(hardResetIn), .hardResetOut(hardResetOut),
      .hardResetOe(hardResetOe), .porConfigIn(porConfigIn),
      .porConfig(porConfig), .pllLock(pllLock), .pllStart(pllStart),
      .pllResetN(pllResetN), .pllTimeout(pllTimeout),
      .timeRefIn(timeRefIn), .timeRef(timeRef));
   rcs_board_model #(.POR_CYC(64)) board (.clk_sys(clk_sys),
      .hardResetOut(hardResetOut), .hardResetOe(hardResetOe),
      .power_on_reset_n(power_on_reset_n), .hardResetIn(hardResetIn),
      .porConfigIn(porConfigIn), .pllLock(pllLock),
      .timeRefIn(timeRefIn));

   // ==========================================================
   // Shared tasks
   // ==========================================================
   task check(input string nm, input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task tally_and_finish();
      $display("Compared %0d, failed %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic wait_oe(input logic v);
      for (int i = 0; i < 45 && hardResetOe !== v; i++) @(negedge clk_sys);
   endtask : wait_oe

   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic sc_power_on(input logic [15:0] s, input int d,
                              input logic to);
      int i;
      board.por_assert();
      check("oe in por", hardResetOe, 1'b1);
      check("valid in por", porConfig.valid, 1'b0);
      board.por_release(s, d);
      check("strap value", porConfig.value, s);
      check("strap valid", porConfig.valid, 1'b1);
      check("line value", hardResetOut, 1'b0);
      check("pll start", pllStart, 1'b1);
      for (i = 0; i < PW + 10 && pllResetN !== 1'b1; i++) begin
         @(negedge clk_sys);
      end
      check("timeout flag", pllTimeout, to);
      check("oe at lock", hardResetOe, 1'b1);
      for (i = 0; i < 45 && hardResetOe !== 1'b0; i++) @(negedge clk_sys);
      check("hold length", i, rcs_pkg::HRST_OUT_CYC);
      check("oe released", hardResetOe, 1'b0);
   endtask : sc_power_on
   task automatic sc_time_ref();
      logic [31:0] c0;
      c0 = timeRef.intrCtrlCount;
      board.tref(5, 8);
      repeat (6) @(negedge clk_sys);
      check("intr count", timeRef.intrCtrlCount, c0 + 5);
      check("time base", timeRef.timeBase, c0 + 5);
      repeat (60) @(negedge clk_sys);
      check("grounded ref", timeRef.intrCtrlCount, c0 + 5);
      // With the enable low the synchroniser is frozen too, so these
      // edges must leave no trace once the enable returns.
      clkEn = 1'b0;
      board.tref(2, 8);
      clkEn = 1'b1;
      repeat (6) @(negedge clk_sys);
      check("frozen ref", timeRef.intrCtrlCount, c0 + 5);
   endtask : sc_time_ref
   task automatic sc_ext_hreset();
      board.ext_hr(10);
      repeat (4) @(negedge clk_sys);
      check("short pulse", hardResetOe, 1'b0);
      board.ext_hr(40);
      repeat (4) @(negedge clk_sys);
      check("long pulse", hardResetOe, 1'b1);
      check("count cleared", timeRef.intrCtrlCount, 32'h0000_0000);
      wait_oe(1'b0);
      check("rerelease", hardResetOe, 1'b0);
   endtask : sc_ext_hreset

   initial begin
      repeat (3) @(negedge clk_sys);
      rst_n = 1'b1;
      sc_power_on(16'hA5C3, 6, 1'b0);
      sc_time_ref();
      sc_ext_hreset();
      sc_power_on(16'h3C5A, 0, 1'b1);
      tally_and_finish();
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      fail_count++;
      tally_and_finish();
   end
endmodule : tb_reset_config_sequencer
